// *** hw/mieu_cfg.svh ***
`ifndef MIEU_CFG_SVH
`define MIEU_CFG_SVH
// bus register byte offsets
`define MIEU_STATUS_OFS  8'h00
`define MIEU_WORK_OFS    8'h04
`define MIEU_TPTR_OFS    8'h08
`define MIEU_THIGH_OFS   8'h0C
`define MIEU_TPAGE_OFS   8'h10
// status register bit positions
`define MIEU_ST_CARRY    0
`define MIEU_ST_ZERO     1
`define MIEU_ST_HALF     2
`define MIEU_ST_SRANGE   3
`define MIEU_ST_SCMP     4
`define MIEU_ST_EXPIRY   5
`define MIEU_ST_SLEEP    6
`define MIEU_ST_BUSY     7
// data memory geometry and special locations
`define MIEU_DMEM_WORDS  256
`define MIEU_PC_LOW_ADDR 8'h06
`define MIEU_LAST_PAGE   4'hF
// reset values
`define MIEU_WORK_RST    8'h00
`define MIEU_PC_RST      12'h000
// instruction cycle counts, one clock per instruction cycle
`define MIEU_CYC_BASE    3'h1
`define MIEU_CYC_EXT     3'h2
`define MIEU_CYC_TBL     3'h3
`define MIEU_CYC_CALL    3'h2
// clocks from table address out to table word capture
`define MIEU_TBL_WAIT    2'h2
`endif

// *** hw/mieu_pkg.sv ***
package mieu_pkg;
  `include "mieu_cfg.svh"

  // operations decoded upstream
  typedef enum logic [4:0] {
    op_nop                             = 5'h00,
    op_add                             = 5'h01,
    op_add_carry                       = 5'h02,
    op_and                             = 5'h03,
    op_ones_complement                 = 5'h04,
    op_decrement                       = 5'h05,
    op_decimal_adjust                  = 5'h06,
    op_clear                           = 5'h07,
    op_clear_bit                       = 5'h08,
    op_nibble_exchange                 = 5'h09,
    op_far_skip_if_null                = 5'h0A,
    op_far_skip_if_null_copy           = 5'h0B,
    op_far_increment_skip_if_null      = 5'h0C,
    op_far_decrement_skip_if_null      = 5'h0D,
    op_far_table_read_page             = 5'h0E,
    op_far_table_read_last             = 5'h0F,
    op_far_pointer_bump_table_read     = 5'h10,
    op_far_pointer_bump_table_read_last = 5'h11,
    op_call                            = 5'h12,
    op_clear_watchdog                  = 5'h13,
    op_power_down                      = 5'h14
  } mieu_op_type;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_exec  = 2'b01,
    st_sleep = 2'b10
  } mieu_state_type;

  typedef struct packed {
    mieu_state_type                        state;
    logic [2:0]                            rem;
    logic [1:0]                            tbl;
    logic [7:0]                            taddr;
    logic                                  skip_pend;
    logic                                  halt_pend;
    logic [`MIEU_DMEM_WORDS-1:0][7:0]      mem;
    logic [7:0]                            wreg;
    logic [7:0]                            tptr;
    logic [7:0]                            thigh;
    logic [3:0]                            tpage;
    logic                                  c;
    logic                                  z;
    logic                                  hc;
    logic                                  srange;
    logic                                  scmp;
    logic                                  expiry;
    logic                                  sleep;
    logic [11:0]                           pc;
    logic [11:0]                           pm_addr;
    logic [11:0]                           stack_data;
    logic                                  push;
    logic                                  done;
    logic                                  skip;
    logic                                  ready;
    logic                                  clk_run;
    logic                                  wd_clear;
    logic                                  ack;
    logic [31:0]                           dat;
  } mieu_core_state_type;
endpackage

// *** hw/mieu_alu.sv ***
`timescale 1ns/10ps
module mieu_alu (
  input  wire mieu_pkg::mieu_op_type op_i,
  input  wire logic [7:0]            a_i,
  input  wire logic [7:0]            m_i,
  input  wire logic [7:0]            imm_i,
  input  wire logic                  use_imm_i,
  input  wire logic                  c_i,
  input  wire logic                  hc_i,
  input  wire logic [2:0]            bit_i,
  output logic      [7:0]            res_o,
  output logic                       c_o,
  output logic                       hc_o,
  output logic                       srange_o,
  output logic                       scmp_o
);
  import mieu_pkg::*;

  logic [7:0] b;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] hsum;
  logic       lo_adj;
  logic       hi_adj;
  logic [8:0] t1;
  logic [8:0] t2;
  logic [7:0] bitclr;

  // adder shared by both add forms, 8-bit wrap
  assign b    = use_imm_i ? imm_i : m_i;
  assign cin  = (op_i == op_add_carry) & c_i;
  assign sum  = {1'b0, a_i} + {1'b0, b} + {8'h00, cin};
  assign hsum = {1'b0, a_i[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  // carry out of bit 3, signed overflow, true sign
  assign hc_o     = hsum[4];
  assign srange_o = (a_i[7] == b[7]) & (sum[7] != a_i[7]);
  assign scmp_o   = srange_o ^ sum[7];

  // decimal fix-up: high nibble judged after the low adjust ripples
  assign lo_adj = (a_i[3:0] > 4'h9) | hc_i;
  assign t1     = {1'b0, a_i} + (lo_adj ? 9'h006 : 9'h000);
  assign hi_adj = (t1[7:4] > 4'h9) | c_i | t1[8];
  assign t2     = t1 + (hi_adj ? 9'h060 : 9'h000);

  // per-bit clear mask for the bit form
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign bitclr[gi] = m_i[gi] & (bit_i != 3'(gi));
    end
  endgenerate

  // result select; carry out only means something for add and adjust
  always_comb begin
    c_o = sum[8];
    case (op_i)
      op_add, op_add_carry: res_o = sum[7:0];
      op_and: res_o = a_i & b;
      op_ones_complement: res_o = ~m_i;
      op_decrement, op_far_decrement_skip_if_null: res_o = m_i - 8'h01;
      op_far_increment_skip_if_null: res_o = m_i + 8'h01;
      op_decimal_adjust: begin
        res_o = t2[7:0];
        c_o   = hi_adj; // set once the decimal sum passed 99
      end
      op_clear: res_o = 8'h00;
      op_clear_bit: res_o = bitclr;
      op_nibble_exchange: res_o = {m_i[3:0], m_i[7:4]};
      default: res_o = m_i;
    endcase
  end
endmodule

// *** hw/mieu_core.sv ***
// Behaviour
// - far skip: three cycles skipping, two otherwise
// - far write of program counter low: three cycles
// - far table read: word to high byte, memory
// - pointer-bump read increments pointer before reading
// - increment/decrement, store, skip when zero
// - copy operand to working, skip if zero
// - nibble exchange; far form two cycles
// - add with carry, five arithmetic flags
// - plain add, memory or immediate, five flags
// - bitwise and affects only zero flag
// - call pushes next address, jumps, two cycles
// - clear byte or bit, no flags
// - watchdog clear clears counter, expiry, sleep
// - ones complement affects only zero flag
// - decimal adjust adds six per nibble
// - decimal adjust changes only carry flag
// - decrement by one, only zero flag
// - power-down stops execution, gates clock, retains
// - power-down clears watchdog counter and prescaler
// - power-down sets sleep, clears expiry flag
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "mieu_cfg.svh"
module mieu_core (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  cmd_valid_i,
  input  wire mieu_pkg::mieu_op_type cmd_op_i,
  input  wire logic                  cmd_ext_i,
  input  wire logic                  cmd_to_mem_i,
  input  wire logic                  cmd_use_imm_i,
  input  wire logic [7:0]            cmd_addr_i,
  input  wire logic [7:0]            cmd_imm_i,
  input  wire logic [2:0]            cmd_bit_i,
  input  wire logic [11:0]           cmd_target_i,
  output logic                       cmd_ready_o,
  output logic                       done_o,
  output logic                       skip_o,
  output logic      [11:0]           pc_o,
  output logic      [11:0]           pm_addr_o,
  input  wire logic [15:0]           pm_data_i,
  output logic                       stack_push_o,
  output logic      [11:0]           stack_data_o,
  output logic                       watchdog_clear_o,
  input  wire logic                  watchdog_timeout_i,
  input  wire logic                  wake_i,
  output logic                       clk_run_o
);
  import mieu_pkg::*;

  mieu_core_state_type r;
  mieu_core_state_type n;
  logic [7:0]          mval;
  logic                accept;
  logic [7:0]          alu_res;
  logic                alu_c;
  logic                alu_hc;
  logic                alu_sr;
  logic                alu_sc;
  logic                is_tbl;
  logic                is_bump;
  logic                is_last;

  // operand fetch from the local data memory
  assign mval    = r.mem[cmd_addr_i];
  assign accept  = r.ready & cmd_valid_i;
  assign is_bump = (cmd_op_i == op_far_pointer_bump_table_read) |
                   (cmd_op_i == op_far_pointer_bump_table_read_last);
  assign is_last = (cmd_op_i == op_far_table_read_last) |
                   (cmd_op_i == op_far_pointer_bump_table_read_last);
  assign is_tbl  = is_bump | is_last | (cmd_op_i == op_far_table_read_page);

  mieu_alu u_alu (
    .op_i      (cmd_op_i),
    .a_i       (r.wreg),
    .m_i       (mval),
    .imm_i     (cmd_imm_i),
    .use_imm_i (cmd_use_imm_i),
    .c_i       (r.c),
    .hc_i      (r.hc),
    .bit_i     (cmd_bit_i),
    .res_o     (alu_res),
    .c_o       (alu_c),
    .hc_o      (alu_hc),
    .srange_o  (alu_sr),
    .scmp_o    (alu_sc)
  );

  // next-state logic for bus slave, executor and sleep control
  always_comb begin
    logic       wr_mem;
    logic       wr_w;
    logic       skp;
    logic       program_counter_low;
    logic [2:0] cyc;
    logic [7:0] st;
    logic [7:0] tp;
    wr_mem = 1'b0;
    wr_w   = 1'b0;
    skp    = 1'b0;
    program_counter_low    = 1'b0;
    cyc    = cmd_ext_i ? `MIEU_CYC_EXT : `MIEU_CYC_BASE;
    st     = 8'h00;
    tp     = r.tptr + 8'h01;
    n          = r;
    n.done     = 1'b0;
    n.skip     = 1'b0;
    n.push     = 1'b0;
    n.wd_clear = 1'b0;
    n.ack      = 1'b0;

    // single-cycle bus slave; the executor below wins on a collision
    st[`MIEU_ST_CARRY]  = r.c;
    st[`MIEU_ST_ZERO]   = r.z;
    st[`MIEU_ST_HALF]   = r.hc;
    st[`MIEU_ST_SRANGE] = r.srange;
    st[`MIEU_ST_SCMP]   = r.scmp;
    st[`MIEU_ST_EXPIRY] = r.expiry;
    st[`MIEU_ST_SLEEP]  = r.sleep;
    st[`MIEU_ST_BUSY]   = ~r.ready;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      n.ack = 1'b1;
      case (wb_adr_i)
        `MIEU_STATUS_OFS: n.dat = {24'h00_0000, st};
        `MIEU_WORK_OFS:   n.dat = {24'h00_0000, r.wreg};
        `MIEU_TPTR_OFS:   n.dat = {24'h00_0000, r.tptr};
        `MIEU_THIGH_OFS:  n.dat = {24'h00_0000, r.thigh};
        `MIEU_TPAGE_OFS:  n.dat = {28'h000_0000, r.tpage};
        default:          n.dat = 32'h0000_0000;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `MIEU_WORK_OFS:  n.wreg  = wb_dat_i[7:0];
          `MIEU_TPTR_OFS:  n.tptr  = wb_dat_i[7:0];
          `MIEU_TPAGE_OFS: n.tpage = wb_dat_i[3:0];
          default:         n.ready = r.ready;
        endcase
      end
    end

    case (r.state)
      st_idle: begin
        if (cmd_valid_i) begin
          case (cmd_op_i)
            // five arithmetic flags from the adder
            op_add, op_add_carry: begin
              wr_mem   = cmd_to_mem_i;
              wr_w     = ~cmd_to_mem_i;
              n.c      = alu_c;
              n.hc     = alu_hc;
              n.srange = alu_sr;
              n.scmp   = alu_sc;
              n.z      = (alu_res == 8'h00);
            end
            // logic class: zero flag only
            op_and, op_ones_complement, op_decrement: begin
              wr_mem = cmd_to_mem_i;
              wr_w   = ~cmd_to_mem_i;
              n.z    = (alu_res == 8'h00);
            end
            op_decimal_adjust: begin
              wr_mem = 1'b1;
              n.c    = alu_c;
            end
            op_clear, op_clear_bit: wr_mem = 1'b1; // flags untouched
            op_nibble_exchange: begin
              wr_mem = cmd_to_mem_i;
              wr_w   = ~cmd_to_mem_i;
            end
            op_far_skip_if_null: skp = (mval == 8'h00);
            op_far_skip_if_null_copy: begin
              wr_w = 1'b1;
              skp  = (mval == 8'h00);
            end
            op_far_increment_skip_if_null, op_far_decrement_skip_if_null: begin
              wr_mem = cmd_to_mem_i;
              wr_w   = ~cmd_to_mem_i;
              skp    = (alu_res == 8'h00);
            end
            op_call: begin
              n.push       = 1'b1;
              n.stack_data = r.pc + 12'h001;
              cyc          = `MIEU_CYC_CALL;
            end
            op_clear_watchdog: begin
              n.wd_clear = 1'b1;
              n.expiry   = 1'b0;
              n.sleep    = 1'b0;
              cyc        = `MIEU_CYC_BASE;
            end
            op_power_down: begin
              n.wd_clear  = 1'b1;
              n.sleep     = 1'b1;
              n.expiry    = 1'b0;
              n.halt_pend = 1'b1;
              cyc         = `MIEU_CYC_BASE;
            end
            default: cyc = cmd_ext_i ? `MIEU_CYC_EXT : `MIEU_CYC_BASE;
          endcase
          // table read: pointer feeds the address, bumped first in the bump forms
          if (is_tbl) begin
            if (is_bump) begin
              n.tptr = tp;
            end
            n.pm_addr = {is_last ? `MIEU_LAST_PAGE : r.tpage, is_bump ? tp : r.tptr};
            n.tbl     = `MIEU_TBL_WAIT;
            n.taddr   = cmd_addr_i;
            cyc       = `MIEU_CYC_TBL;
            program_counter_low       = (cmd_addr_i == `MIEU_PC_LOW_ADDR);
          end
          if (wr_mem) begin
            n.mem[cmd_addr_i] = alu_res;
            program_counter_low = (cmd_addr_i == `MIEU_PC_LOW_ADDR);
          end
          if (wr_w) begin
            n.wreg = (cmd_op_i == op_far_skip_if_null_copy) ? mval : alu_res;
          end
          // next address: jump, low-byte rewrite or step past a skip
          n.pc = r.pc + 12'h001 + {11'h000, skp};
          if (cmd_op_i == op_call) begin
            n.pc = cmd_target_i;
          end else if (program_counter_low && !is_tbl) begin
            n.pc[7:0] = alu_res;
          end
          // extra cycle for a taken skip or a far low-byte write
          n.rem       = cyc + {2'b00, skp} + {2'b00, program_counter_low & cmd_ext_i};
          n.skip_pend = skp;
          n.state     = st_exec;
          n.ready     = 1'b0;
        end
      end
      st_exec: begin
        // table word lands after the program memory latency
        if (r.tbl != 2'h0) begin
          n.tbl = r.tbl - 2'h1;
          if (r.tbl == 2'h1) begin
            n.thigh        = pm_data_i[15:8];
            n.mem[r.taddr] = pm_data_i[7:0];
            if (r.taddr == `MIEU_PC_LOW_ADDR) begin
              n.pc[7:0] = pm_data_i[7:0];
            end
          end
        end
        n.rem = r.rem - 3'h1;
        if (r.rem == 3'h1) begin
          n.done      = 1'b1;
          n.skip      = r.skip_pend;
          n.halt_pend = 1'b0;
          if (r.halt_pend) begin
            n.state   = st_sleep; // clock gated, contents kept
            n.clk_run = 1'b0;
          end else begin
            n.state = st_idle;
            n.ready = 1'b1;
          end
        end
      end
      st_sleep: begin
        if (wake_i) begin
          n.state   = st_idle;
          n.clk_run = 1'b1;
          n.ready   = 1'b1;
        end
      end
      default: begin
        n.state = st_idle;
        n.ready = 1'b1;
      end
    endcase

    // expiry set wins over any clear in the same cycle
    if (watchdog_timeout_i) begin
      n.expiry = 1'b1;
    end
  end

  // one register stage for all state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r         <= '0;
      r.wreg    <= `MIEU_WORK_RST;
      r.pc      <= `MIEU_PC_RST;
      r.ready   <= 1'b1;
      r.clk_run <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign wb_dat_o         = r.dat;
  assign wb_ack_o         = r.ack;
  assign cmd_ready_o      = r.ready;
  assign done_o           = r.done;
  assign skip_o           = r.skip;
  assign pc_o             = r.pc;
  assign pm_addr_o        = r.pm_addr;
  assign stack_push_o     = r.push;
  assign stack_data_o     = r.stack_data;
  assign watchdog_clear_o = r.wd_clear;
  assign clk_run_o        = r.clk_run;

  // checks: latencies and effects tied to the accepting edge
  // done raised by edge N is only sampled at the tick after it
  sequence s_done_in2;
    !done_o ##1 !done_o ##1 done_o;
  endsequence

  sequence s_done_in3;
    !done_o ##1 !done_o ##1 !done_o ##1 done_o;
  endsequence

  property p_skip_taken;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_ext_i && cmd_op_i == op_far_skip_if_null && mval == 8'h00
      |=> s_done_in3 ##0 skip_o;
  endproperty
  a_skip_taken: assert property (p_skip_taken)
    else $error("taken far skip not three cycles");

  property p_skip_not_taken;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_ext_i && cmd_op_i == op_far_skip_if_null && mval != 8'h00
      |=> s_done_in2 ##0 !skip_o;
  endproperty
  a_skip_not_taken: assert property (p_skip_not_taken)
    else $error("untaken far skip not two cycles");

  property p_pc_low_write;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_ext_i && cmd_op_i == op_add && cmd_to_mem_i &&
    cmd_addr_i == `MIEU_PC_LOW_ADDR |=> s_done_in3;
  endproperty
  a_pc_low_write: assert property (p_pc_low_write)
    else $error("far low program counter write not three cycles");

  property p_table_read;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && is_tbl &&
    cmd_addr_i != `MIEU_PC_LOW_ADDR |=> s_done_in3;
  endproperty
  a_table_read: assert property (p_table_read)
    else $error("far table read not three cycles");

  property p_bump_first;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_op_i == op_far_pointer_bump_table_read
      |=> r.tptr == $past(r.tptr) + 8'h01 && pm_addr_o[7:0] == r.tptr;
  endproperty
  a_bump_first: assert property (p_bump_first)
    else $error("table address does not use bumped pointer");

  property p_call;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_op_i == op_call |=> stack_push_o &&
    stack_data_o == $past(pc_o) + 12'h001 && pc_o == $past(cmd_target_i) ##2 done_o;
  endproperty
  a_call: assert property (p_call)
    else $error("call push, target or length wrong");

  property p_watchdog_clear;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_op_i == op_clear_watchdog && !watchdog_timeout_i
      |=> watchdog_clear_o && !r.expiry && !r.sleep;
  endproperty
  a_watchdog_clear: assert property (p_watchdog_clear)
    else $error("watchdog clear left a flag set");

  property p_power_down;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_op_i == op_power_down && !watchdog_timeout_i
      |=> watchdog_clear_o && r.sleep && !r.expiry ##1 done_o && !clk_run_o && !cmd_ready_o;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power-down entry wrong");

  property p_clear_no_flags;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_op_i == op_clear |=> r.mem[$past(cmd_addr_i)] == 8'h00 &&
    {r.c, r.z, r.hc, r.srange, r.scmp} == $past({r.c, r.z, r.hc, r.srange, r.scmp});
  endproperty
  a_clear_no_flags: assert property (p_clear_no_flags)
    else $error("clear left data or touched flags");

  property p_add_wrap;
    @(posedge clk_i) disable iff (!resetn_i)
    accept && cmd_op_i == op_add && !cmd_to_mem_i && cmd_use_imm_i
      |=> r.wreg == 8'($past(r.wreg) + $past(cmd_imm_i));
  endproperty
  a_add_wrap: assert property (p_add_wrap)
    else $error("add result not modulo 256");
endmodule

// *** bench/mieu_pm_model.sv ***
`timescale 1ns/10ps
module mieu_pm_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] addr_i,
  output logic      [15:0] data_o
);
  // registered read, one clock late; each word carries its own address so a wrong fetch shows
  always_ff @(posedge clk_i) begin
    data_o <= {4'hC, addr_i};
  end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import mieu_pkg::*;
  // driven by the bench
  logic        clk_i = 1'b0, resetn_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        valid = 1'b0, ext = 1'b0, tm = 1'b0, ui = 1'b0, wake = 1'b0, wdt = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [2:0]  bsel = 3'h1;
  logic [7:0]  adr = 8'h00, addr = 8'h00, imm = 8'h00, rd;
  logic [11:0] tgt = 12'h123, pc, pmad, sdat, sdatc, pcv;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  mieu_op_type op = op_nop;
  // seen from the design
  logic        ack, rdy, done, skip, spush, wdc, crun, pushed, wdcd, sk;
  logic [15:0] pmd;
  int          miscompares = 0, n_compared = 0, n;

  // system clock
  always #25 clk_i = ~clk_i;

  mieu_core uut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cmd_valid_i(valid), .cmd_op_i(op), .cmd_ext_i(ext), .cmd_to_mem_i(tm),
    .cmd_use_imm_i(ui), .cmd_addr_i(addr), .cmd_imm_i(imm), .cmd_bit_i(bsel),
    .cmd_target_i(tgt), .cmd_ready_o(rdy), .done_o(done), .skip_o(skip), .pc_o(pc),
    .pm_addr_o(pmad), .pm_data_i(pmd), .stack_push_o(spush), .stack_data_o(sdat),
    .watchdog_clear_o(wdc), .watchdog_timeout_i(wdt), .wake_i(wake), .clk_run_o(crun));
  mieu_pm_model pm (.clk_i(clk_i), .addr_i(pmad), .data_o(pmd));

  // single bus cycle, held until the edge that sees ack
  task automatic wb(input logic [7:0] a, input logic [7:0] d = 8'h00, input logic w = 1'b0);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask

  // one instruction, f = {ext, to_mem, imm}; n counts edges from accept to done
  task automatic ex(input mieu_op_type o, input logic [2:0] f = 3'b000,
                    input logic [7:0] a = 8'h00, input logic [7:0] i = 8'h00);
    @(posedge clk_i);
    {valid, ext, tm, ui, addr, imm} <= {1'b1, f, a, i};
    op <= o;
    do @(posedge clk_i); while (rdy !== 1'b1);
    valid <= 1'b0;
    n = 0;
    pushed = 1'b0;
    wdcd = 1'b0;
    do begin
      @(negedge clk_i);
      if (spush === 1'b1) sdatc = sdat;
      pushed = pushed | (spush === 1'b1);
      wdcd = wdcd | (wdc === 1'b1);
      if (done !== 1'b1) n++;
    end while (done !== 1'b1 && n < 8);
    sk = skip;
  endtask

  // memory has no bus window, so read it back through the working register
  task automatic rdm(input logic [7:0] a);
    wb(8'h04, 8'h00, 1'b1);
    ex(op_add, 3'b000, a);
    wb(8'h04);
  endtask

  task automatic t_arith;
    wb(8'h04, 8'h7F, 1'b1);
    ex(op_add, 3'b101, 8'h00, 8'h01);
    `CHK("add cycles", 2, n)
    wb(8'h04);
    `CHK("add sum", 8'h80, rd)
    wb(8'h00);
    `CHK("add flags", 5'h0C, rd[4:0])
    wb(8'h04, 8'h01, 1'b1);
    ex(op_add, 3'b010, 8'h10);
    wb(8'h04, 8'hFF, 1'b1);
    ex(op_add_carry, 3'b100, 8'h10);
    wb(8'h04);
    `CHK("adc sum", 8'h00, rd)
    wb(8'h00);
    `CHK("adc flags", 5'h07, rd[4:0])
    ex(op_add_carry, 3'b100, 8'h10);
    wb(8'h04);
    `CHK("adc carry in", 8'h02, rd)
  endtask

  task automatic t_bcd;
    wb(8'h04, 8'h9B, 1'b1);
    ex(op_add, 3'b001);
    ex(op_decimal_adjust, 3'b110, 8'h40);
    wb(8'h00);
    `CHK("bcd flags", 5'h11, rd[4:0])
    rdm(8'h40);
    `CHK("bcd sum", 8'h01, rd)
    ex(op_decrement, 3'b100, 8'h40);
    wb(8'h04);
    `CHK("dec work", 8'h00, rd)
    ex(op_ones_complement, 3'b110, 8'h40);
    rdm(8'h40);
    `CHK("cpl mem", 8'hFE, rd)
    ex(op_nibble_exchange, 3'b100, 8'h40);
    `CHK("swap cycles", 2, n)
    wb(8'h04);
    `CHK("swap work", 8'hEF, rd)
    ex(op_clear_bit, 3'b110, 8'h40);
    rdm(8'h40);
    `CHK("bit clear", 8'hFC, rd)
    ex(op_and, 3'b001, 8'h00, 8'h0F);
    wb(8'h04);
    `CHK("and work", 8'h0C, rd)
  endtask

  task automatic t_skip;
    ex(op_far_skip_if_null, 3'b100, 8'h20);
    `CHK("skip cycles", 3, n)
    `CHK("skip taken", 1'b1, sk)
    ex(op_far_skip_if_null, 3'b100, 8'h10);
    `CHK("noskip cycles", 2, n)
    ex(op_far_decrement_skip_if_null, 3'b110, 8'h10);
    `CHK("dec skip", 1'b1, sk)
    rdm(8'h10);
    `CHK("dec skip mem", 8'h00, rd)
    wb(8'h04, 8'h77, 1'b1);
    ex(op_far_skip_if_null_copy, 3'b100, 8'h20);
    `CHK("copy skip", 1'b1, sk)
    wb(8'h04);
    `CHK("copy work", 8'h00, rd)
    ex(op_add, 3'b110, 8'h06);
    `CHK("pcl cycles", 3, n)
  endtask

  task automatic t_table;
    wb(8'h08, 8'h33, 1'b1);
    wb(8'h10, 8'h02, 1'b1);
    ex(op_far_pointer_bump_table_read, 3'b110, 8'h30);
    `CHK("tbl cycles", 3, n)
    `CHK("tbl addr", 12'h234, pmad)
    wb(8'h0C);
    `CHK("tbl high", 8'hC2, rd)
    rdm(8'h30);
    `CHK("tbl low", 8'h34, rd)
    ex(op_far_table_read_last, 3'b110, 8'h30);
    `CHK("last addr", 12'hF34, pmad)
    ex(op_clear, 3'b110, 8'h30);
    rdm(8'h30);
    `CHK("clear", 8'h00, rd)
  endtask

  task automatic t_call;
    @(negedge clk_i);
    pcv = pc;
    ex(op_call);
    `CHK("call cycles", 2, n)
    `CHK("push", 1'b1, pushed)
    `CHK("push data", pcv + 12'h001, sdatc)
    `CHK("call pc", 12'h123, pc)
  endtask

  task automatic t_sleep;
    wb(8'h04, 8'h5A, 1'b1);
    ex(op_power_down);
    `CHK("wd clear", 1'b1, wdcd)
    repeat (3) @(negedge clk_i);
    `CHK("clk gated", 1'b0, crun)
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    @(negedge clk_i);
    `CHK("clk back", 1'b1, crun)
    wb(8'h00);
    `CHK("sleep flags", 2'b10, rd[6:5])
    wb(8'h04);
    `CHK("retained", 8'h5A, rd)
    wb(8'h20);
    `CHK("unmapped", 8'h00, rd)
    @(posedge clk_i);
    wdt <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    ex(op_clear_watchdog);
    `CHK("wd clear 2", 1'b1, wdcd)
    wb(8'h00);
    `CHK("wd flags", 2'b00, rd[6:5])
  endtask

  // verdict and end of run
  task automatic close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_arith;
    t_bcd;
    t_skip;
    t_table;
    t_call;
    t_sleep;
    close_out;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
endmodule
